/* rtl/bridge_tail_pkg.sv */
// Constants, states and carriers shared by the bridge configuration header tail
package bridge_tail_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
  localparam logic [7:0] INT_LINE_OFFSET = 8'h3c;
  localparam logic [7:0] INT_PIN_OFFSET = 8'h3d;
  localparam logic [7:0] CTRL_OFFSET = 8'h3e;

  // ----------------------------------------------------------------
  // Fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PTR_VALUE = 8'h50;
  localparam logic [7:0] INT_LINE_RESET = 8'hff;
  localparam logic [7:0] INT_PIN_VALUE = 8'h00;
  localparam logic [3:0] TOP_NIBBLE_VALUE = 4'h0;
  localparam logic [8:0] LOW_CTRL_VALUE = 9'h000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions; a register sits in the dword at 8 times its byte lane
  // ----------------------------------------------------------------
  localparam int LINE_LANE = 0;
  localparam int PIN_LANE = 1;
  localparam int CTRL_LANE = 2;
  localparam int LEN_SEL_BIT = 9;
  localparam int FLAG_BIT = 10;
  localparam int MSG_EN_BIT = 11;
  localparam int SEC_INTX_LINES = 4;

  // ----------------------------------------------------------------
  // Discard timer lengths, in secondary clock cycles
  // ----------------------------------------------------------------
  localparam int DISCARD_LONG_CYCLES = 32768;
  localparam int DISCARD_SHORT_CYCLES = 1024;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_COUNT = 2'b01,
    T_DROP = 2'b11,
    T_HOLD = 2'b10
  } discard_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_access_t;

  typedef struct packed {
    logic valid;
    logic fatal;
  } err_msg_t;

endpackage

/* rtl/discard_timer.sv */
// Secondary discard timer for one delayed completion
`timescale 1ns/1ns
`default_nettype none

module discard_timer #(
  parameter int LONG_CYCLES = bridge_tail_pkg::DISCARD_LONG_CYCLES,
  parameter int SHORT_CYCLES = bridge_tail_pkg::DISCARD_SHORT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic short_select,
  input wire logic completion_at_head,
  input wire logic request_repeated,
  output logic discard
);

  localparam int CW = $clog2(LONG_CYCLES + 1);

  if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad_length
    $error("discard_timer: lengths must satisfy 1 <= short <= long");
  end

  bridge_tail_pkg::discard_state_t state;
  logic [CW-1:0] count;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Hold after a drop so the same entry cannot be timed twice while
  // the queue is still removing it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= bridge_tail_pkg::T_IDLE;
    else
      unique case (state)
        bridge_tail_pkg::T_IDLE:
          if (completion_at_head && !request_repeated)
            state <= bridge_tail_pkg::T_COUNT;
        bridge_tail_pkg::T_COUNT:
          if (request_repeated || !completion_at_head)
            state <= bridge_tail_pkg::T_IDLE;
          else if (count == '0)
            state <= bridge_tail_pkg::T_DROP;
        bridge_tail_pkg::T_DROP:
          state <= bridge_tail_pkg::T_HOLD;
        bridge_tail_pkg::T_HOLD:
          if (!completion_at_head)
            state <= bridge_tail_pkg::T_IDLE;
      endcase
  end

  // ----------------------------------------------------------------
  // Count; length is taken when counting starts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= '0;
    else if (state == bridge_tail_pkg::T_IDLE)
      count <= short_select ? CW'(SHORT_CYCLES - 1) : CW'(LONG_CYCLES - 1);
    else if (state == bridge_tail_pkg::T_COUNT && count != '0)
      count <= count - CW'(1);
  end

  assign discard = (state == bridge_tail_pkg::T_DROP);

endmodule // discard_timer

`default_nettype wire

/* rtl/bridge_config_header_tail.sv */
// Configuration header tail: capability pointer, interrupt line and pin, upper bridge control
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Capability pointer always reads the fixed power management offset.
// - Interrupt line reads all ones after reset: no line assigned.
// - Interrupt line stores whatever software writes; nothing else uses it.
// - Interrupt pin is read-only and always reads zero.
// - Secondary interrupts are passed on towards the primary interface.
// - Control bits 15 to 12 read zero and ignore writes.
// - Message enable set plus discard expiry sends an error message upstream.
// - Expiry message is nonfatal unless error reporting selects fatal.
// - Enable clear still sends a message if reporting present and unmasked.
// - Message enable counts only in conventional secondary mode.
// - Discard sets a status flag; reads one on error; software clears it.
// - Control bit 9 picks a long or short discard timer.
// - Timer starts at queue head; no repeat before expiry drops the transaction.
module bridge_config_header_tail #(
  parameter int LONG_CYCLES = bridge_tail_pkg::DISCARD_LONG_CYCLES,
  parameter int SHORT_CYCLES = bridge_tail_pkg::DISCARD_SHORT_CYCLES,
  parameter bit AER_PRESENT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_valid,
  input wire bridge_tail_pkg::cfg_access_t cfg,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic conventional_pci_mode,
  input wire logic completion_at_head,
  input wire logic request_repeated,
  input wire logic aer_discard_mask,
  input wire logic aer_severity_fatal,
  input wire logic [bridge_tail_pkg::SEC_INTX_LINES-1:0] sec_intx_b,
  output logic [bridge_tail_pkg::SEC_INTX_LINES-1:0] pri_intx_assert,
  output bridge_tail_pkg::err_msg_t err_msg,
  output logic transaction_drop
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Control sits in the upper half of the dword at 3Ch
  localparam int CTRL_BASE = 8 * bridge_tail_pkg::CTRL_LANE;

  function automatic logic hits_dword(input logic [7:0] addr, input logic [7:0] base);
    hits_dword = (addr[7:2] == base[7:2]);
  endfunction

  logic rd_cap;
  logic rd_int;
  logic wr_cap;
  logic wr_int;
  logic [7:0] interrupt_line_scratch;
  logic discard_expiry_msg_enable;
  logic discard_expiry_flag;
  logic secondary_discard_length_select;
  logic [15:0] bridge_extension_control;
  logic send_msg;

  assign rd_cap = cfg_valid && !cfg.wr && hits_dword(cfg.addr, bridge_tail_pkg::CAP_PTR_OFFSET);
  assign rd_int = cfg_valid && !cfg.wr && hits_dword(cfg.addr, bridge_tail_pkg::INT_LINE_OFFSET);
  assign wr_cap = cfg_valid && cfg.wr && hits_dword(cfg.addr, bridge_tail_pkg::CAP_PTR_OFFSET);
  assign wr_int = cfg_valid && cfg.wr && hits_dword(cfg.addr, bridge_tail_pkg::INT_LINE_OFFSET);

  // ----------------------------------------------------------------
  // Interrupt line scratch
  // ----------------------------------------------------------------
  // Kept only for software; no logic here reads it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      interrupt_line_scratch <= bridge_tail_pkg::INT_LINE_RESET;
    else if (wr_int && cfg.be[bridge_tail_pkg::LINE_LANE])
      interrupt_line_scratch <= cfg.wdata[8*bridge_tail_pkg::LINE_LANE +: 8];
  end

  // ----------------------------------------------------------------
  // Bridge control, upper byte and bit 9
  // ----------------------------------------------------------------
  // Pin lane, top nibble and the capability dword have no storage, so
  // writes there are taken and dropped
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      discard_expiry_msg_enable <= bridge_tail_pkg::CTRL_RESET[bridge_tail_pkg::MSG_EN_BIT];
      secondary_discard_length_select <= bridge_tail_pkg::CTRL_RESET[bridge_tail_pkg::LEN_SEL_BIT];
    end
    else if (wr_int)
    begin
      if (cfg.be[bridge_tail_pkg::CTRL_LANE + 1])
        discard_expiry_msg_enable <= cfg.wdata[CTRL_BASE + bridge_tail_pkg::MSG_EN_BIT];
      if (cfg.be[bridge_tail_pkg::CTRL_LANE + 1])
        secondary_discard_length_select <= cfg.wdata[CTRL_BASE + bridge_tail_pkg::LEN_SEL_BIT];
    end
  end

  // Write one to clear; a discard in the same cycle wins so no event is lost
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      discard_expiry_flag <= bridge_tail_pkg::CTRL_RESET[bridge_tail_pkg::FLAG_BIT];
    else if (transaction_drop)
      discard_expiry_flag <= 1'b1;
    else if (wr_int && cfg.be[bridge_tail_pkg::CTRL_LANE + 1] && cfg.wdata[CTRL_BASE + bridge_tail_pkg::FLAG_BIT])
      discard_expiry_flag <= 1'b0;
  end

  assign bridge_extension_control = {bridge_tail_pkg::TOP_NIBBLE_VALUE, discard_expiry_msg_enable,
    discard_expiry_flag, secondary_discard_length_select, bridge_tail_pkg::LOW_CTRL_VALUE};

  // ----------------------------------------------------------------
  // Configuration read path
  // ----------------------------------------------------------------
  // Every access is answered the next cycle; other header dwords read zero here
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_ack <= 1'b0;
    else
      cfg_ack <= cfg_valid;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_rdata <= '0;
    else if (rd_cap)
      cfg_rdata <= {24'h000000, bridge_tail_pkg::CAP_PTR_VALUE};
    else if (rd_int)
      cfg_rdata <= {bridge_extension_control, bridge_tail_pkg::INT_PIN_VALUE, interrupt_line_scratch};
    else if (cfg_valid && !cfg.wr)
      cfg_rdata <= '0;
  end

  // ----------------------------------------------------------------
  // Discard timer
  // ----------------------------------------------------------------
  discard_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_discard_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .short_select(secondary_discard_length_select),
    .completion_at_head(completion_at_head),
    .request_repeated(request_repeated),
    .discard(transaction_drop)
  );

  // ----------------------------------------------------------------
  // Error message on discard
  // ----------------------------------------------------------------
  // Enable only counts in conventional mode; the unmasked reporting path
  // sends regardless of the enable
  assign send_msg = transaction_drop &&
    ((discard_expiry_msg_enable && conventional_pci_mode) ||
     (AER_PRESENT && !aer_discard_mask));

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_msg <= '0;
    else
    begin
      err_msg.valid <= send_msg;
      err_msg.fatal <= send_msg && AER_PRESENT && aer_severity_fatal;
    end
  end

  // ----------------------------------------------------------------
  // Secondary interrupt forwarding
  // ----------------------------------------------------------------
  // Pins are asynchronous; two plain stages settle them before the inverter
  // reads them, at the cost of a third cycle of latency
  for (genvar i = 0; i < bridge_tail_pkg::SEC_INTX_LINES; i++)
  begin : g_intx
    logic meta_b;
    logic sync_b;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        meta_b <= 1'b1;
        sync_b <= 1'b1;
        pri_intx_assert[i] <= 1'b0;
      end
      else
      begin
        meta_b <= sec_intx_b[i];
        sync_b <= meta_b;
        pri_intx_assert[i] <= !sync_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic line_written;
  logic [16:0] head_run;

  // The wait counter saturates, so the short length must stay below its top
  if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || SHORT_CYCLES >= (2 ** $bits(head_run)) - 1)
  begin : g_bad_length
    $error("bridge_config_header_tail: need 1 <= short <= long and short below the wait counter top");
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      line_written <= 1'b0;
    else if (wr_int && cfg.be[bridge_tail_pkg::LINE_LANE])
      line_written <= 1'b1;
  end

  // Cycles the completion has waited at the head without a repeat
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      head_run <= '0;
    else if (!completion_at_head || request_repeated || transaction_drop)
      head_run <= '0;
    else if (head_run != '1)
      head_run <= head_run + 17'h00001;
  end

  a_cap_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_cap |=> cfg_ack && cfg_rdata == {24'h000000, bridge_tail_pkg::CAP_PTR_VALUE})
    else $error("capability pointer read wrong value");

  a_line_default: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !line_written |-> interrupt_line_scratch == bridge_tail_pkg::INT_LINE_RESET)
    else $error("interrupt line left its reset value without a write");

  a_line_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_int && cfg.be[bridge_tail_pkg::LINE_LANE]
      |=> interrupt_line_scratch == $past(cfg.wdata[8*bridge_tail_pkg::LINE_LANE +: 8]))
    else $error("interrupt line did not store written value");

  a_line_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_int |=> cfg_rdata[7:0] == $past(interrupt_line_scratch))
    else $error("interrupt line did not return stored value");

  a_pin_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_int |=> cfg_ack && cfg_rdata[15:8] == bridge_tail_pkg::INT_PIN_VALUE)
    else $error("interrupt pin read nonzero");

  a_intx_forward: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sec_intx_b[0] [*3] |=> pri_intx_assert[0])
    else $error("secondary interrupt not forwarded");

  a_top_nibble: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_int |=> cfg_rdata[31:28] == bridge_tail_pkg::TOP_NIBBLE_VALUE)
    else $error("reserved control bits read nonzero");

  a_msg_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    transaction_drop && discard_expiry_msg_enable && conventional_pci_mode |=> err_msg.valid)
    else $error("enabled discard sent no error message");

  a_msg_severity: assert property (@(posedge sys_clk) disable iff (!rst_b)
    err_msg.valid |-> err_msg.fatal == (AER_PRESENT && $past(aer_severity_fatal)))
    else $error("error message severity wrong");

  a_aer_path: assert property (@(posedge sys_clk) disable iff (!rst_b)
    transaction_drop && !discard_expiry_msg_enable && AER_PRESENT && !aer_discard_mask
      |=> err_msg.valid)
    else $error("unmasked discard sent no error message");

  a_mode_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    transaction_drop && !conventional_pci_mode && !(AER_PRESENT && !aer_discard_mask)
      |=> !err_msg.valid)
    else $error("error message sent outside conventional mode");

  a_no_spurious: assert property (@(posedge sys_clk) disable iff (!rst_b)
    err_msg.valid |-> $past(transaction_drop))
    else $error("error message without a discard");

  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    transaction_drop |=> discard_expiry_flag)
    else $error("discard flag not set");

  a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    discard_expiry_flag && !(wr_int && cfg.be[bridge_tail_pkg::CTRL_LANE + 1]
      && cfg.wdata[CTRL_BASE + bridge_tail_pkg::FLAG_BIT]) |=> discard_expiry_flag)
    else $error("discard flag lost without a clear");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_int && cfg.be[bridge_tail_pkg::CTRL_LANE + 1] && cfg.wdata[CTRL_BASE + bridge_tail_pkg::FLAG_BIT]
      && !transaction_drop |=> !discard_expiry_flag)
    else $error("discard flag not cleared by software");

  a_wait_least: assert property (@(posedge sys_clk) disable iff (!rst_b)
    transaction_drop |-> head_run > 17'(SHORT_CYCLES))
    else $error("transaction dropped before the short discard time");

  a_repeat_saves: assert property (@(posedge sys_clk) disable iff (!rst_b)
    request_repeated |=> !transaction_drop)
    else $error("transaction dropped despite a repeated request");

  a_cap_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_cap |=> cfg_ack && $stable(cfg_rdata))
    else $error("capability write not accepted cleanly");

  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_ack |-> $past(cfg_valid))
    else $error("access answered without a request");

endmodule // bridge_config_header_tail

`default_nettype wire

/* sim/upstream_port_model.sv */
// Upstream port model that takes in error messages sent by the bridge
`timescale 1ns/1ns
`default_nettype none

module upstream_port_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire bridge_tail_pkg::err_msg_t err_msg,
  output var int nonfatal_count,
  output var int fatal_count
);
  // ----------------------------------------------------------------
  // Message intake
  // ----------------------------------------------------------------
  // The port never stalls a message, so counting is all it needs to do
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nonfatal_count <= 0;
      fatal_count <= 0;
    end
    else if (err_msg.valid === 1'b1)
    begin
      if (err_msg.fatal === 1'b1)
        fatal_count <= fatal_count + 1;
      else
        nonfatal_count <= nonfatal_count + 1;
    end
  end
endmodule // upstream_port_model

`default_nettype wire

/* sim/test_bridge_config_header_tail.sv */
// Self-checking testbench for the bridge configuration header tail
`timescale 1ns/1ns
`default_nettype none

module test_bridge_config_header_tail;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Short timer lengths keep the run brief; expectations follow them
  localparam int LONG_LEN = 64;
  localparam int SHORT_LEN = 8;
  logic sys_clk, rst_b, cfg_valid, cfg_ack, conventional_pci_mode, completion_at_head;
  logic request_repeated, aer_discard_mask, aer_severity_fatal, transaction_drop;
  bridge_tail_pkg::cfg_access_t cfg;
  logic [31:0] cfg_rdata, rd;
  logic [3:0] sec_intx_b, pri_intx_assert;
  bridge_tail_pkg::err_msg_t err_msg;
  int err_total, total_checks, nf_count, f_count, hits;
  int cycles = 0;

  bridge_config_header_tail #(.LONG_CYCLES(LONG_LEN), .SHORT_CYCLES(SHORT_LEN), .AER_PRESENT(1'b1)) uut (
    .sys_clk, .rst_b, .cfg_valid, .cfg, .cfg_ack, .cfg_rdata, .conventional_pci_mode,
    .completion_at_head, .request_repeated, .aer_discard_mask, .aer_severity_fatal,
    .sec_intx_b, .pri_intx_assert, .err_msg, .transaction_drop
  );

  upstream_port_model host (
    .sys_clk, .rst_b, .err_msg, .nonfatal_count(nf_count), .fatal_count(f_count)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered at a falling edge; one idle cycle after each access so valid never toggles twice in a step
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wdata);
    cfg_valid = 1'b1;
    cfg = '{wr: wr, addr: addr, be: be, wdata: wdata};
    @(negedge sys_clk);
    cfg_valid = 1'b0;
    check({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
    @(negedge sys_clk);
  endtask

  // One timed completion that is never repeated; also clears the flag first
  task automatic discard(input logic [15:0] ctrl, input logic conv, input logic msk, input logic sev,
                         input int len, input int exp_nf, input int exp_f);
    int n, nf0, f0;
    access(1'b1, 8'h3c, 4'h8, {ctrl | 16'h0400, 16'h0000});
    conventional_pci_mode = conv;
    aer_discard_mask = msk;
    aer_severity_fatal = sev;
    nf0 = nf_count;
    f0 = f_count;
    n = 0;
    completion_at_head = 1'b1;
    while (transaction_drop !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(n, len + 1);
    repeat (2) @(negedge sys_clk);
    completion_at_head = 1'b0;
    check(nf_count - nf0, exp_nf);
    check(f_count - f0, exp_f);
    access(1'b0, 8'h3c, 4'hf, 32'h0);
    check({16'h0, rd[31:16]}, {16'h0, (ctrl & 16'h0a00) | 16'h0400});
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Whole run needs well under a thousand cycles; this ceiling only cuts a hang
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    cfg_valid = 1'b0;
    cfg = '0;
    conventional_pci_mode = 1'b1;
    completion_at_head = 1'b0;
    request_repeated = 1'b0;
    aer_discard_mask = 1'b1;
    aer_severity_fatal = 1'b0;
    sec_intx_b = 4'hf;
    err_total = 0;
    total_checks = 0;
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    access(1'b0, 8'h34, 4'hf, 32'h0);
    check(rd, 32'h0000_0050);
    access(1'b0, 8'h3c, 4'hf, 32'h0);
    check(rd, 32'h0000_00ff);
    access(1'b1, 8'h34, 4'hf, 32'hffff_ffff);
    access(1'b0, 8'h34, 4'hf, 32'h0);
    check(rd, 32'h0000_0050);
    access(1'b1, 8'h3c, 4'hf, 32'hfaff_a55a);
    access(1'b0, 8'h3c, 4'hf, 32'h0);
    check(rd, 32'h0a00_005a);
    access(1'b0, 8'h40, 4'hf, 32'h0);
    check(rd, 32'h0000_0000);
    // Forwarded interrupts: active-low secondary pins become active-high levels
    sec_intx_b = 4'b1010;
    repeat (3) @(negedge sys_clk);
    check({28'h0, pri_intx_assert}, 32'h5);
    sec_intx_b = 4'b0101;
    repeat (3) @(negedge sys_clk);
    check({28'h0, pri_intx_assert}, 32'ha);
    sec_intx_b = 4'hf;
    discard(16'h0a00, 1'b1, 1'b1, 1'b0, SHORT_LEN, 1, 0);
    discard(16'h0800, 1'b1, 1'b1, 1'b0, LONG_LEN, 1, 0);
    discard(16'h0a00, 1'b1, 1'b1, 1'b1, SHORT_LEN, 0, 1);
    discard(16'h0200, 1'b1, 1'b0, 1'b0, SHORT_LEN, 1, 0);
    discard(16'h0200, 1'b1, 1'b1, 1'b0, SHORT_LEN, 0, 0);
    discard(16'h0a00, 1'b0, 1'b1, 1'b0, SHORT_LEN, 0, 0);
    access(1'b1, 8'h3c, 4'h8, 32'h0e00_0000);
    access(1'b0, 8'h3c, 4'hf, 32'h0);
    check(rd, 32'h0a00_005a);
    // Master keeps repeating while the completion stays at the head: nothing may be dropped
    completion_at_head = 1'b1;
    repeat (4) @(negedge sys_clk);
    request_repeated = 1'b1;
    hits = 0;
    repeat (SHORT_LEN + 6)
    begin
      @(negedge sys_clk);
      if (transaction_drop !== 1'b0)
        hits++;
    end
    request_repeated = 1'b0;
    completion_at_head = 1'b0;
    check(hits, 0);
    print_verdict();
  end
endmodule // test_bridge_config_header_tail

`default_nettype wire
